// *** hdl/qaso_pkg.sv ***
/*
 * Package for the quad converter serial output and power control block: constants, types
 * and the carrier structs shared by the block and its FIFO.
 * Assumes a single 20 MHz system clock and a sample clock arriving as a slow pin.
 */
package qaso_pkg;

    // ****************************************************************
    // Sizes.
    // ****************************************************************
    localparam int unsigned NUM_CH = 4;        // Converter channels.
    localparam int unsigned SAMPLE_BITS = 8;   // Bits per sample word.
    localparam int unsigned BIT_CNT_W = 3;     // Width of a bit index.
    localparam int unsigned FIFO_DEPTH = 32;   // Words held between converter and serializer.

    // ****************************************************************
    // Codes and timing.
    // ****************************************************************
    localparam logic [7:0] MSB_FLIP = 8'h80;   // Offset binary to twos complement.
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7; // Index of the final bit of a word.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned STANDBY_WAKE_NS = 600; // Wake time with PLL kept alive.
    localparam int unsigned STANDBY_WAKE_CYC =
        (STANDBY_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FULL_WAKE_US = 375; // Wake time after a long full power-down.
    localparam int unsigned FULL_WAKE_CYC = FULL_WAKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_CNT_W = 13;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [1:0] {
        QASO_ST_ACTIVE,
        QASO_ST_DOWN,
        QASO_ST_WAKE
    } qaso_state_t;

    // One sample from every channel, carried as a single FIFO word.
    typedef struct packed {
        logic [NUM_CH-1:0][SAMPLE_BITS-1:0] smp;
    } qaso_word_t;

    // Analog-side enables driven by the power logic.
    typedef struct packed {
        logic ref_en;
        logic ref_buf_en;
        logic pll_en;
        logic bias_en;
    } qaso_power_t;

endpackage : qaso_pkg

// *** hdl/qaso_fifo.sv ***
/*
 * Synchronous FIFO with parameter width and depth, valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
module qaso_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    // ****************************************************************
    // Storage and pointers.
    // ****************************************************************
    logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
    logic [AW-1:0] wr_ptr;          // Next slot to write.
    logic [AW-1:0] rd_ptr;          // Next slot to read.
    logic [AW:0] count;             // Words held; one bit wider for an honest full.
    logic do_wr;
    logic do_rd;

    // Full is compared at the counter's own width: an AW-bit depth would wrap to zero.
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    // Memory writes carry no reset so the array can map to RAM.
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : qaso_fifo

// *** hdl/qaso_top.sv ***
/*
 * Serial output and power control of a four-channel eight-bit converter. Samples enter
 * once per sample clock, get coded, pass a FIFO and are shifted out eight bits per sample
 * period on four lanes with a frame clock and a bit clock.
 * Assumes the sample clock and power-down pin arrive asynchronously and are synchronised
 * here; the bit-rate enable comes from the PLL model (bit_tick_i, system-clock domain).
 */
module qaso_top (
    input wire logic clk_i,                     // System clock, 20 MHz.
    input wire logic rst_n_i,                   // Asynchronous active-low reset.
    input wire logic sample_clk_i,              // Sample clock pin, asynchronous.
    input wire logic power_down_pin_i,          // Full power-down pin, asynchronous.
    input wire logic serial_io_output_mode_pin_i, // Reduced-swing strap, asynchronous.
    input wire logic bit_tick_i,                // One-cycle bit-rate enable.
    input wire logic [qaso_pkg::NUM_CH-1:0][qaso_pkg::SAMPLE_BITS-1:0] sample_i,
    input wire logic [qaso_pkg::NUM_CH-1:0] ch_power_down_i, // Per-channel power-down.
    input wire logic standby_i,                 // Standby with PLL kept alive.
    input wire logic reduced_swing_i,           // Register select of reduced swing.
    input wire logic high_drive_i,              // Raised termination and drive current.
    input wire logic twos_comp_i,               // Twos complement coding.
    input wire logic pll_low_rate_i,            // PLL accepts low sample rates.
    output logic [qaso_pkg::NUM_CH-1:0] lane_o, // Serial data lanes.
    output logic [qaso_pkg::NUM_CH-1:0] lane_oe_o, // Lane driver enables.
    output logic frame_clock_out_o,             // Frame clock.
    output logic frame_clock_out_oe_o,
    output logic bit_clock_out_o,               // Bit clock.
    output logic bit_clock_out_oe_o,
    output logic reduced_swing_o,               // Driver swing select.
    output logic high_drive_o,                  // Driver current select.
    output logic pll_low_rate_o,                // PLL range select.
    output qaso_pkg::qaso_power_t power_o,      // Analog enables.
    output logic ready_o,                       // Data valid after wake-up.
    output logic overflow_o                     // Sticky: a sample was dropped.
);

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    logic [2:0] sync_a;  // First stage; read only by sync_b.
    logic [2:0] sync_b;  // Second stage.
    logic smp_clk_d;     // Delayed sample clock for edge finding.
    logic smp_rise;
    logic pd_pin;
    logic strap_rs;

    // Two flops per asynchronous pin before any logic reads them.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            smp_clk_d <= 1'b0;
        end else begin
            sync_a <= {serial_io_output_mode_pin_i, power_down_pin_i, sample_clk_i};
            sync_b <= sync_a;
            smp_clk_d <= sync_b[0];
        end
    end
    assign smp_rise = sync_b[0] && !smp_clk_d;
    assign pd_pin = sync_b[1];
    assign strap_rs = sync_b[2];

    // ****************************************************************
    // Power state.
    // ****************************************************************
    qaso_pkg::qaso_state_t state;
    qaso_pkg::qaso_state_t next_state;
    logic [qaso_pkg::WAKE_CNT_W-1:0] wake_cnt; // Cycles left of wake-up.
    logic was_standby; // Wake from standby uses the short figure.
    logic running;

    // The pin overrides standby; standby keeps the PLL alive, so its wake is short.
    always_comb begin
        next_state = state;
        case (state)
            qaso_pkg::QASO_ST_ACTIVE: begin
                if (pd_pin || standby_i) begin
                    next_state = qaso_pkg::QASO_ST_DOWN;
                end
            end
            qaso_pkg::QASO_ST_DOWN: begin
                if (!pd_pin && !standby_i) begin
                    next_state = qaso_pkg::QASO_ST_WAKE;
                end
            end
            default: begin
                if (pd_pin || standby_i) begin
                    next_state = qaso_pkg::QASO_ST_DOWN;
                end else if (wake_cnt == '0) begin
                    next_state = qaso_pkg::QASO_ST_ACTIVE;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= qaso_pkg::QASO_ST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // Wake counter; the full figure is a worst case, shorter power-downs recover sooner
    // but logic cannot measure reference charge, so it always waits the long figure.
    // An outage counts as standby until the pin is seen high in it; the last DOWN cycle
    // already sees the pin low, so the choice is remembered rather than sampled again.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_cnt <= '0;
            was_standby <= 1'b0;
        end else if (state == qaso_pkg::QASO_ST_DOWN) begin
            if (pd_pin) begin
                was_standby <= 1'b0;
                wake_cnt <= qaso_pkg::WAKE_CNT_W'(qaso_pkg::FULL_WAKE_CYC);
            end else if (was_standby) begin
                wake_cnt <= qaso_pkg::WAKE_CNT_W'(qaso_pkg::STANDBY_WAKE_CYC);
            end
        end else if (next_state == qaso_pkg::QASO_ST_DOWN) begin
            was_standby <= 1'b1; // Entering an outage; the pin may still claim it.
        end else if (state == qaso_pkg::QASO_ST_WAKE && wake_cnt != '0) begin
            wake_cnt <= wake_cnt - 1'b1;
        end
    end

    assign running = (state == qaso_pkg::QASO_ST_ACTIVE);
    assign ready_o = running;

    // Analog enables: the pin kills everything, standby keeps the PLL.
    always_comb begin
        power_o.ref_en = !pd_pin && !standby_i;
        power_o.ref_buf_en = !pd_pin && !standby_i;
        power_o.bias_en = !pd_pin && !standby_i;
        power_o.pll_en = !pd_pin;
    end

    // Configuration ports are never cleared by power-down, so they hold across it.
    assign reduced_swing_o = reduced_swing_i || strap_rs;
    assign high_drive_o = high_drive_i;
    assign pll_low_rate_o = pll_low_rate_i;

    // ****************************************************************
    // Sample capture into the FIFO.
    // ****************************************************************
    qaso_pkg::qaso_word_t cap_word;
    qaso_pkg::qaso_word_t fifo_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;

    // Coding is applied on entry: offset binary by default, MSB flipped for twos complement.
    always_comb begin
        for (int i = 0; i < qaso_pkg::NUM_CH; i++) begin
            cap_word.smp[i] = twos_comp_i ? (sample_i[i] ^ qaso_pkg::MSB_FLIP)
                                          : sample_i[i];
        end
    end

    // A sample arriving while running with the FIFO full is dropped and flagged.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_o <= 1'b0;
        end else if (smp_rise && running && !fifo_in_ready) begin
            overflow_o <= 1'b1;
        end
    end

    qaso_fifo #(
        .WIDTH($bits(qaso_pkg::qaso_word_t)),
        .DEPTH(qaso_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(smp_rise && running),
        .in_ready_o(fifo_in_ready),
        .in_data_i(cap_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_word)
    );

    // ****************************************************************
    // Serializer.
    // ****************************************************************
    qaso_pkg::qaso_word_t shift_word; // Word being sent.
    logic [qaso_pkg::BIT_CNT_W-1:0] bit_idx;
    logic shifting;
    logic bit_clk;

    // A new word is taken at the end of the previous one, only when bits are due.
    assign fifo_pop = bit_tick_i && running && fifo_out_valid
                      && (!shifting || bit_idx == qaso_pkg::LAST_BIT);

    // Shift MSB first; eight bit ticks make one sample period.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_word <= '0;
            bit_idx <= '0;
            shifting <= 1'b0;
        end else if (!running) begin
            shifting <= 1'b0;
            bit_idx <= '0;
        end else if (bit_tick_i) begin
            if (fifo_pop) begin
                shift_word <= fifo_word;
                bit_idx <= '0;
                shifting <= 1'b1;
            end else if (shifting && bit_idx != qaso_pkg::LAST_BIT) begin
                bit_idx <= bit_idx + 1'b1;
            end else begin
                shifting <= 1'b0;
            end
        end
    end

    // Bit clock toggles every tick while running so each bit sees one clock half-period edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_clk <= 1'b0;
        end else if (bit_tick_i && running) begin
            bit_clk <= !bit_clk;
        end
    end

    // Registered lane outputs; disabled channels and power-down float the drivers.
    genvar ch;
    generate
        for (ch = 0; ch < qaso_pkg::NUM_CH; ch++) begin : g_lane
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    lane_o[ch] <= 1'b0;
                    lane_oe_o[ch] <= 1'b0;
                end else begin
                    lane_o[ch] <= shifting && shift_word.smp[ch][
                        qaso_pkg::LAST_BIT - bit_idx];
                    lane_oe_o[ch] <= running && !ch_power_down_i[ch];
                end
            end
        end
    endgenerate

    // Frame clock high for the first half of each word, low for the second.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_clock_out_o <= 1'b0;
            frame_clock_out_oe_o <= 1'b0;
            bit_clock_out_o <= 1'b0;
            bit_clock_out_oe_o <= 1'b0;
        end else begin
            frame_clock_out_o <= shifting && !bit_idx[qaso_pkg::BIT_CNT_W-1];
            frame_clock_out_oe_o <= running;
            bit_clock_out_o <= bit_clk;
            bit_clock_out_oe_o <= running;
        end
    end

endmodule : qaso_top

// *** tb/qaso_checker.sv ***
/*
 * Concurrent checks on the ports of the serial output and power block.
 * Assumes it is bound into every instance of the block and sees only its ports.
 */
module qaso_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_down_pin_i,
    input wire logic standby_i,
    input wire logic [qaso_pkg::NUM_CH-1:0] ch_power_down_i,
    input wire logic reduced_swing_i,
    input wire logic high_drive_i,
    input wire logic pll_low_rate_i,
    input wire logic [qaso_pkg::NUM_CH-1:0] lane_oe_o,
    input wire logic frame_clock_out_o,
    input wire logic frame_clock_out_oe_o,
    input wire logic bit_clock_out_o,
    input wire logic bit_clock_out_oe_o,
    input wire logic reduced_swing_o,
    input wire logic high_drive_o,
    input wire logic pll_low_rate_o,
    input wire qaso_pkg::qaso_power_t power_o,
    input wire logic ready_o
);
    // ****************************************************************
    // Helper state.
    // ****************************************************************
    logic [12:0] wake_cnt; // Cycles spent not ready, saturating.
    logic down_by_pin; // The pin was seen high at some point in the current outage.
    logic prev_frame;
    logic prev_bclk;
    logic [2:0] bits_since; // Bit clock toggles since the frame rose.

    // Outage length; saturation keeps a long outage from wrapping back to a fail.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_cnt <= 13'h0000;
            down_by_pin <= 1'b0;
        end else if (ready_o) begin
            wake_cnt <= 13'h0000;
            down_by_pin <= 1'b0;
        end else begin
            wake_cnt <= (wake_cnt == 13'h1fff) ? wake_cnt : wake_cnt + 13'h0001;
            down_by_pin <= down_by_pin | power_down_pin_i;
        end
    end

    // Word position counted on the bit clock, restarted at each frame rise.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_frame <= 1'b0;
            prev_bclk <= 1'b0;
            bits_since <= 3'h0;
        end else begin
            prev_frame <= frame_clock_out_o;
            prev_bclk <= bit_clock_out_o;
            if (frame_clock_out_o && !prev_frame) begin
                bits_since <= 3'h0;
            end else if (bit_clock_out_o != prev_bclk) begin
                bits_since <= bits_since + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************************************************
    // Sequences and assertions.
    // ****************************************************************
    sequence s_pin_held;
        power_down_pin_i[*6];
    endsequence
    sequence s_standby_held;
        (standby_i && !power_down_pin_i)[*3];
    endsequence

    a_pd_oe_off: assert property (s_pin_held |-> lane_oe_o == 4'h0 && !frame_clock_out_oe_o
        && !bit_clock_out_oe_o) else $error("drivers enabled in power-down");
    a_pd_power_off: assert property (s_pin_held |-> power_o == 4'h0)
        else $error("analog enables on in power-down");
    a_pd_not_ready: assert property (s_pin_held |-> !ready_o)
        else $error("ready during power-down");
    a_full_wake_len: assert property ($rose(ready_o) && down_by_pin
        |-> wake_cnt >= qaso_pkg::FULL_WAKE_CYC) else $error("pin wake-up too short");
    a_standby_pll_on: assert property (s_standby_held |-> power_o.pll_en && !ready_o)
        else $error("standby lost the PLL or stayed ready");
    a_standby_fast_wake: assert property ($fell(standby_i) && !down_by_pin
        && !power_down_pin_i |-> ##[1:20] ready_o) else $error("standby wake-up too slow");
    a_chan_float: assert property (ch_power_down_i != 4'h0 ##1 $stable(ch_power_down_i)
        |-> (ch_power_down_i & lane_oe_o) == 4'h0) else $error("powered-down lane driven");
    a_swing_sel: assert property (reduced_swing_i |-> reduced_swing_o)
        else $error("reduced swing not selected");
    a_drive_pass: assert property (high_drive_o == high_drive_i
        && pll_low_rate_o == pll_low_rate_i) else $error("drive or PLL select wrong");
    a_frame_half: assert property ($fell(frame_clock_out_o) && bit_clock_out_oe_o
        |-> bits_since == 3'h3) else $error("frame high for wrong bit count");
endmodule : qaso_checker

bind qaso_top qaso_checker u_qaso_checker (.clk_i, .rst_n_i, .power_down_pin_i, .standby_i,
    .ch_power_down_i, .reduced_swing_i, .high_drive_i, .pll_low_rate_i, .lane_oe_o,
    .frame_clock_out_o, .frame_clock_out_oe_o, .bit_clock_out_o, .bit_clock_out_oe_o,
    .reduced_swing_o, .high_drive_o, .pll_low_rate_o, .power_o, .ready_o);

// *** tb/qaso_rx_model.sv ***
/*
 * Behavioural lane receiver at the far end: deserialises the four lanes on the bit clock
 * and aligns words on the frame clock rise.
 * Assumes the block's registered outputs on the same system clock.
 */
module qaso_rx_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] lane_i,
    input wire logic [3:0] lane_oe_i,
    input wire logic frame_i,
    input wire logic bclk_i,
    input wire logic bclk_oe_i,
    output logic word_valid_o,
    output qaso_pkg::qaso_word_t word_o
);
    logic [3:0] wire_v; // Line level seen at the receiver.
    logic [3:0] last_v;
    logic prev_bclk;
    logic prev_frame;
    logic [3:0] cnt; // Bits of the current word so far, 0 before alignment.
    logic [3:0][7:0] sh;
    logic [3:0][7:0] next_sh;

    // A released line shows the inverse of its last level, so stale bits never pass.
    assign wire_v = (lane_oe_i & lane_i) | (~lane_oe_i & ~last_v);
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            next_sh[c] = {sh[c][6:0], wire_v[c]}; // Each lane MSB first
        end
    end

    // Shift one bit per bit clock edge; the frame rise marks bit 7 of a word.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {last_v, prev_bclk, prev_frame, cnt, sh, word_valid_o} <= '0;
            word_o <= '0;
        end else begin
            last_v <= wire_v;
            prev_bclk <= bclk_i;
            word_valid_o <= 1'b0;
            if (bclk_oe_i && bclk_i != prev_bclk) begin
                prev_frame <= frame_i;
                sh <= next_sh;
                if (frame_i && !prev_frame) begin
                    cnt <= 4'h1;
                end else if (cnt != 4'h0) begin
                    cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
                end
                if (cnt == 4'h7 && !(frame_i && !prev_frame)) begin
                    word_valid_o <= 1'b1; // Eight bits per sample word
                    word_o <= next_sh;
                end
            end
        end
    end
endmodule : qaso_rx_model

// *** tb/test_qaso_top.sv ***
/*
 * Self-checking bench of the serial output and power block with a lane receiver model.
 * Assumes the checker is bound in; the sample clock is made here at 400 ns.
 */
module test_qaso_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, sample_clk_i = 1'b0, power_down_pin_i = 1'b0;
    logic strap = 1'b0, bit_tick_i = 1'b0, tick_en = 1'b0, standby_i = 1'b0;
    logic reduced_swing_i = 1'b0, high_drive_i = 1'b0, twos_comp_i = 1'b0;
    logic pll_low_rate_i = 1'b0, rx_valid;
    logic [3:0][7:0] sample_i = '0;
    logic [3:0] ch_power_down_i = 4'h0, lane_o, lane_oe_o;
    logic frame_o, frame_oe, bclk_o, bclk_oe, swing_o, drive_o, low_rate_o, ready_o, overflow_o;
    qaso_pkg::qaso_power_t power_o;
    qaso_pkg::qaso_word_t rx_word;
    logic [31:0] exp_q[$]; // Expected words in sending order.
    int num_errors = 0, total_checks = 0, cycles = 0, n;

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) bit_tick_i <= tick_en; // One bit per clock, eight per sample.

    qaso_top u_qaso_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_clk_i(sample_clk_i),
        .power_down_pin_i(power_down_pin_i), .serial_io_output_mode_pin_i(strap),
        .bit_tick_i(bit_tick_i), .sample_i(sample_i), .ch_power_down_i(ch_power_down_i),
        .standby_i(standby_i), .reduced_swing_i(reduced_swing_i), .high_drive_i(high_drive_i),
        .twos_comp_i(twos_comp_i), .pll_low_rate_i(pll_low_rate_i), .lane_o(lane_o),
        .lane_oe_o(lane_oe_o), .frame_clock_out_o(frame_o), .frame_clock_out_oe_o(frame_oe),
        .bit_clock_out_o(bclk_o), .bit_clock_out_oe_o(bclk_oe), .reduced_swing_o(swing_o),
        .high_drive_o(drive_o), .pll_low_rate_o(low_rate_o), .power_o(power_o),
        .ready_o(ready_o), .overflow_o(overflow_o));
    qaso_rx_model u_qaso_rx_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .lane_i(lane_o),
        .lane_oe_i(lane_oe_o), .frame_i(frame_o), .bclk_i(bclk_o), .bclk_oe_i(bclk_oe),
        .word_valid_o(rx_valid), .word_o(rx_word));

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Settle after the edge so NBA updates have landed.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc

    // One clean sample clock period; data is garbled once its hold time is over.
    task automatic send(input logic [31:0] w, input logic keep);
        sample_i <= w;
        #7 sample_clk_i = 1'b1; // Clean, retimed edge
        if (keep) exp_q.push_back(twos_comp_i ? w ^ 32'h8080_8080 : w);
        #200 sample_clk_i = 1'b0;
        sample_i = ~w;
        #193;
    endtask : send

    // Boundary codes first, then random words.
    task automatic stream(input int k);
        for (int i = 0; i < k; i++) begin
            send(i == 0 ? 32'hff80_7f00 : i == 1 ? 32'h007f_80ff : $urandom(), 1'b1);
        end
    endtask : stream

    task automatic drain(input int k);
        cyc(k);
        chk("words left", 32'h0000_0000, exp_q.size());
    endtask : drain

    task automatic wait_ready(input int k);
        n = 0;
        while (ready_o !== 1'b1 && n < k) begin
            cyc(1);
            n++;
        end
    endtask : wait_ready

    // Every word the receiver assembles is matched against the oldest expectation.
    always @(posedge clk_i) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("extra word", 32'h0, 32'h1);
            else chk("word", exp_q.pop_front(), rx_word);
        end
    end

    // The run must not hang past the longest wake-up plus traffic.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        void'($urandom(32'hb0f3));
        cyc(2);
        rst_n_i <= 1'b1;
        cyc(1);
        chk("reset state", 32'h0000_007c, {ready_o, power_o, overflow_o, swing_o});
        // Every combination of strap and driver settings.
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            {strap, reduced_swing_i, high_drive_i, pll_low_rate_i} <= i[3:0];
            cyc(4);
            chk("drive sel", {i[3] | i[2], i[1:0]}, {swing_o, drive_o, low_rate_o});
        end
        @(posedge clk_i);
        {strap, reduced_swing_i, tick_en} <= 3'h1;
        stream(12);
        drain(40);
        @(posedge clk_i) twos_comp_i <= 1'b1;
        stream(6);
        drain(40);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i) ch_power_down_i <= 4'h1 << c;
            cyc(4);
            chk("lane enables", 4'hf ^ (4'h1 << c), lane_oe_o);
        end
        @(posedge clk_i);
        {ch_power_down_i, reduced_swing_i, power_down_pin_i} <= 6'h03;
        cyc(8);
        chk("pd enables", 32'h0, {lane_oe_o, frame_oe, bclk_oe, power_o, ready_o});
        send($urandom(), 1'b0);
        send($urandom(), 1'b0);
        @(posedge clk_i) power_down_pin_i <= 1'b0;
        wait_ready(9000); // No data relied on before ready
        chk("pin wake", 32'h1, n >= qaso_pkg::FULL_WAKE_CYC && n < 7520);
        chk("kept swing", 32'h1, swing_o);
        stream(4);
        drain(40); // Coding setting survived
        @(posedge clk_i) standby_i <= 1'b1;
        cyc(4);
        chk("standby", 32'h2, {power_o.pll_en, ready_o});
        @(posedge clk_i) standby_i <= 1'b0;
        wait_ready(100);
        chk("fast wake", 32'h1, n <= qaso_pkg::STANDBY_WAKE_CYC + 4);
        @(posedge clk_i) {twos_comp_i, tick_en} <= 2'h0;
        cyc(4);
        // Far side stalls: the FIFO fills, refuses, then drains.
        for (int i = 0; i < qaso_pkg::FIFO_DEPTH + 2; i++) send($urandom(), i < qaso_pkg::FIFO_DEPTH);
        chk("overflow", 32'h1, overflow_o);
        @(posedge clk_i) tick_en <= 1'b1;
        drain(320);
        final_report();
    end
endmodule : test_qaso_top
